//--- rtl/apss_pkg.sv
// Purpose: shared constants for the host-supply power-up supervisor
// Assumes: 50 MHz system clock
// Notes: register offsets are word indices on the plain register port
package apss_pkg;
  // ==========================================================
  // timing
  localparam int unsigned ClkHz = 50000000;
  localparam int unsigned InitMs = 6;
  localparam int unsigned StrapMs = 2;
  localparam int unsigned ErrMs = 10;
  localparam int unsigned DeglitchUs = 125;
  localparam int unsigned InitCyc = InitMs * (ClkHz / 1000);
  localparam int unsigned StrapCyc = StrapMs * (ClkHz / 1000);
  localparam int unsigned ErrCyc = ErrMs * (ClkHz / 1000);
  localparam int unsigned DeglitchCyc = DeglitchUs * (ClkHz / 1000000);
  // ==========================================================
  // register map
  localparam logic [3:0] RegSupplyCtl = 4'h0;
  localparam logic [3:0] RegPhotoCtl = 4'h1;
  localparam logic [3:0] RegStatus = 4'h2;
  localparam logic [3:0] RegRailCtl = 4'h3;
  // supply control fields
  localparam int unsigned FldSetLo = 0;
  localparam int unsigned FldDisable = 2;
  localparam int unsigned FldErrMask = 3;
  // photo control fields
  localparam int unsigned FldGainLo = 0;
  localparam int unsigned FldRefSel = 2;
  localparam int unsigned FldInAmp = 3;
  localparam int unsigned FldGainAmp = 4;
  // status fields
  localparam int unsigned FldGood = 0;
  localparam int unsigned FldErr = 1;
  localparam int unsigned FldFault = 2;
  localparam int unsigned FldHostOk = 3;
  localparam int unsigned FldStateLo = 4;
  localparam logic [7:0] PhotoRst = 8'h00;
  // ==========================================================
  // host-supply levels: 1.5 V, 1.8 V, 2.5 V, 3.3 V
  typedef enum logic [1:0] {
    APSS_V1P5,
    APSS_V1P8,
    APSS_V2P5,
    APSS_V3P3
  } apss_level_e;
  // strap sensing outcome, as seen by the analog strap detector
  typedef enum logic [1:0] {
    APSS_STRAP_RES620,
    APSS_STRAP_GND,
    APSS_STRAP_RAIL,
    APSS_STRAP_CAP330
  } apss_strap_e;
  // photo gain: 5x, 11x, 20x, 35x
  typedef enum logic [1:0] {
    APSS_G5,
    APSS_G11,
    APSS_G20,
    APSS_G35
  } apss_gain_e;
  typedef enum logic [2:0] {
    APSS_INIT,
    APSS_STRAP,
    APSS_ENABLE,
    APSS_RUN,
    APSS_FAULT
  } apss_state_e;
endpackage : apss_pkg

//--- rtl/apss_if.sv
// Purpose: carrier between sequencer and power-good filter
// Assumes: one clock domain
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface apss_if;
  logic goodRaw;
  logic goodClean;
  modport filt (input goodRaw, output goodClean);
  modport seq (output goodRaw, input goodClean);
endinterface : apss_if
`default_nettype wire

//--- rtl/apss_deglitch.sv
// Purpose: 3-flop synchroniser and deglitch filter for host-supply good
// Assumes: input is asynchronous to clk_sys
// Notes: output changes only after the input held a new level FiltCyc cycles
`timescale 1ns/10ps
`default_nettype none
module apss_deglitch #(
  parameter int unsigned FiltCyc = apss_pkg::DeglitchCyc
) (
  input wire logic clk_sys,
  input wire logic rst,
  apss_if.filt link
);
  localparam int unsigned CntW = $clog2(FiltCyc + 1);
  initial
  begin
    if (FiltCyc < 1) $error("apss_deglitch: FiltCyc must be at least 1");
  end
  logic [2:0] syncFf;
  logic [CntW-1:0] holdCntFf;
  logic goodFf;
  logic stable;
  logic differs;
  // ==========================================================
  // synchroniser: a change counts only when stages two and three agree
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) syncFf <= 3'h0;
    else syncFf <= {syncFf[1:0], link.goodRaw};
  end
  assign stable = (syncFf[1] == syncFf[2]);
  assign differs = stable && (syncFf[2] != goodFf);
  // deglitch: shorter disturbances restart the count and are dropped
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      holdCntFf <= '0;
      goodFf <= 1'b0;
    end
    else if (!differs) holdCntFf <= '0; // RL6
    else if (holdCntFf == CntW'(FiltCyc - 1))
    begin
      goodFf <= syncFf[2]; // RL6
      holdCntFf <= '0;
    end
    else holdCntFf <= holdCntFf + 1'b1;
  end
  assign link.goodClean = goodFf;
endmodule : apss_deglitch
`default_nettype wire

//--- rtl/apss_supervisor.sv
// Purpose: power-up sequencing and supervision of the host supply,
//   plus photo reference and gain control decode
// Assumes: 50 MHz clk_sys, rst follows supply qualification
// Notes: analog regulators and amplifiers sit outside; this drives them
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RL1] after supply qualification the block waits 6 ms before anything.
// [RL2] the strap is then sensed for 2 ms and its decode loads the setting.
// [RL3] strap and setting pick one of four levels: 1.5, 1.8, 2.5, 3.3 V.
// [RL4] the regulator is enabled and host access opens only at power-good.
// [RL5] software may rewrite the setting and turn the regulator off.
// [RL6] power-good is filtered so disturbances under 125 us are ignored.
// [RL7] the error flag sets if power-good is low 10 ms after enable or change.
// [RL8] a raised error flag with the mask clear puts the block in fault.
// [RL9] the photo reference is 50 mV only with ref select and an amp on.
// [RL10] the gain stage offers exactly four gains, 5x, 11x, 20x, 35x.
// [RL11] a new gain written by software applies at once.
// [RL12] ref select steers the gain stage reference and its 5 mV offset.
// [RL13] the core regulator enable is constant high whenever powered.
// [RL14] all intervals come from clock counters; async inputs are synced.
module apss_supervisor #(
  parameter int unsigned InitCycles = apss_pkg::InitCyc,
  parameter int unsigned StrapCycles = apss_pkg::StrapCyc,
  parameter int unsigned ErrCycles = apss_pkg::ErrCyc,
  parameter int unsigned FiltCycles = apss_pkg::DeglitchCyc
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic [1:0] supplySelectStrap,
  input wire logic hostSupplyGoodRaw,
  output logic hostRegulatorOn,
  output logic [1:0] hostSupplySetting,
  output logic hostAccessOk,
  output logic hostSupplyFault,
  output logic photoRefLow,
  output logic photoGainRefSel,
  output logic [1:0] photoGainSel,
  output logic photoInputAmpOn,
  output logic photoGainAmpOn,
  output logic coreRegulatorOn
);
  localparam int unsigned SeqW = 32;
  initial
  begin
    if (InitCycles < 1 || StrapCycles < 1 || ErrCycles < 1)
      $error("apss_supervisor: interval counts must be at least 1");
  end
  apss_if goodLink ();
  apss_pkg::apss_state_e stateFf;
  apss_pkg::apss_state_e nxt_state;
  logic [SeqW-1:0] seqCntFf;
  logic [SeqW-1:0] errCntFf;
  logic [2:0] strapSyncFf [2];
  logic [1:0] settingFf;
  logic disableFf;
  logic maskFf;
  logic errFf;
  logic [7:0] photoFf;
  logic [7:0] nxt_rdData;
  logic [7:0] rdDataFf;
  logic wrSupply;
  logic wrPhoto;
  logic setChanged;
  logic errTimeout;
  logic good;
  logic [1:0] strapNow;
  // ==========================================================
  // power-good conditioning
  assign goodLink.goodRaw = hostSupplyGoodRaw;
  apss_deglitch #(
    .FiltCyc(FiltCycles)
  ) u_deglitch (
    .clk_sys(clk_sys),
    .rst(rst),
    .link(goodLink)
  );
  assign good = goodLink.goodClean; // RL14
  // ==========================================================
  // strap synchroniser, one 3-flop chain per strap bit
  for (genvar b = 0; b < 2; b++)
  begin : g_strap
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst) strapSyncFf[b] <= 3'h0;
      else strapSyncFf[b] <= {strapSyncFf[b][1:0], supplySelectStrap[b]};
    end
    assign strapNow[b] = strapSyncFf[b][2];
  end
  // ==========================================================
  // sequence state
  always_comb
  begin
    nxt_state = stateFf;
    case (stateFf)
      apss_pkg::APSS_INIT:
        if (seqCntFf == SeqW'(InitCycles - 1))
          nxt_state = apss_pkg::APSS_STRAP; // RL1
      apss_pkg::APSS_STRAP:
        if (seqCntFf == SeqW'(StrapCycles - 1))
          nxt_state = apss_pkg::APSS_ENABLE; // RL2
      apss_pkg::APSS_ENABLE:
        if (good) nxt_state = apss_pkg::APSS_RUN; // RL4
        else if (errFf && !maskFf) nxt_state = apss_pkg::APSS_FAULT;
      apss_pkg::APSS_RUN:
        if (errFf && !maskFf) nxt_state = apss_pkg::APSS_FAULT; // RL8
      apss_pkg::APSS_FAULT:
        if (!errFf || maskFf) nxt_state = apss_pkg::APSS_RUN; // RL8
      default: nxt_state = apss_pkg::APSS_INIT;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) stateFf <= apss_pkg::APSS_INIT;
    else stateFf <= nxt_state;
  end
  // interval counter restarts on every state change
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) seqCntFf <= '0;
    else if (nxt_state != stateFf) seqCntFf <= '0; // RL14
    else if (stateFf == apss_pkg::APSS_INIT ||
             stateFf == apss_pkg::APSS_STRAP)
      seqCntFf <= seqCntFf + 1'b1;
  end
  // ==========================================================
  // register writes
  assign wrSupply = regWrEn && (regAddr == apss_pkg::RegSupplyCtl);
  assign wrPhoto = regWrEn && (regAddr == apss_pkg::RegPhotoCtl);
  // writes are ignored until host access opens, as the host is not powered
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      settingFf <= apss_pkg::APSS_V1P5;
      disableFf <= 1'b0;
      maskFf <= 1'b0;
    end
    else if (stateFf == apss_pkg::APSS_STRAP &&
             nxt_state == apss_pkg::APSS_ENABLE)
      settingFf <= strapNow; // RL2 RL3
    else if (wrSupply && hostAccessOk)
    begin
      settingFf <= regWrData[apss_pkg::FldSetLo +: 2]; // RL5
      disableFf <= regWrData[apss_pkg::FldDisable]; // RL5
      maskFf <= regWrData[apss_pkg::FldErrMask];
    end
  end
  // photo control applies straight away, no restart needed
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) photoFf <= apss_pkg::PhotoRst;
    else if (wrPhoto && hostAccessOk) photoFf <= regWrData; // RL11
  end
  // ==========================================================
  // error timer, rearmed on enable and on each setting change
  assign setChanged = wrSupply && hostAccessOk &&
                      (regWrData[apss_pkg::FldSetLo +: 2] != settingFf ||
                       (disableFf && !regWrData[apss_pkg::FldDisable]));
  assign errTimeout = (errCntFf == SeqW'(ErrCycles - 1));
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) errCntFf <= '0;
    else if ((stateFf == apss_pkg::APSS_STRAP &&
              nxt_state == apss_pkg::APSS_ENABLE) || setChanged)
      errCntFf <= '0; // RL7
    else if (!hostRegulatorOn || good) errCntFf <= '0;
    else if (!errTimeout) errCntFf <= errCntFf + 1'b1;
  end
  // flag holds while power-good stays low with the regulator on; clears once it recovers or the regulator is off
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) errFf <= 1'b0;
    else if (errTimeout && !good && hostRegulatorOn) errFf <= 1'b1; // RL7
    else if (good || !hostRegulatorOn) errFf <= 1'b0;
  end
  // ==========================================================
  // read port, data one cycle after the strobe; unmapped reads zero
  always_comb
  begin
    nxt_rdData = 8'h00;
    if (regAddr == apss_pkg::RegSupplyCtl)
    begin
      nxt_rdData[apss_pkg::FldSetLo +: 2] = settingFf;
      nxt_rdData[apss_pkg::FldDisable] = disableFf;
      nxt_rdData[apss_pkg::FldErrMask] = maskFf;
    end
    else if (regAddr == apss_pkg::RegPhotoCtl) nxt_rdData = photoFf;
    else if (regAddr == apss_pkg::RegStatus)
    begin
      nxt_rdData[apss_pkg::FldGood] = good;
      nxt_rdData[apss_pkg::FldErr] = errFf;
      nxt_rdData[apss_pkg::FldFault] = (stateFf == apss_pkg::APSS_FAULT);
      nxt_rdData[apss_pkg::FldHostOk] = hostAccessOk;
      nxt_rdData[apss_pkg::FldStateLo +: 3] = stateFf;
    end
    else if (regAddr == apss_pkg::RegRailCtl)
      nxt_rdData[0] = coreRegulatorOn;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) rdDataFf <= 8'h00;
    else if (regRdEn) rdDataFf <= nxt_rdData;
    else rdDataFf <= 8'h00;
  end
  assign regRdData = rdDataFf;
  // ==========================================================
  // outputs
  // access opens at the first filtered good, even one that only comes
  // after a slow start has already tripped the error flag and the fault
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) hostAccessOk <= 1'b0;
    else if (good && stateFf != apss_pkg::APSS_INIT &&
             stateFf != apss_pkg::APSS_STRAP)
      hostAccessOk <= 1'b1; // RL4
  end
  assign hostRegulatorOn = !disableFf &&
    (stateFf == apss_pkg::APSS_ENABLE || stateFf == apss_pkg::APSS_RUN ||
     stateFf == apss_pkg::APSS_FAULT); // RL4 RL5
  assign hostSupplySetting = settingFf; // RL3
  assign hostSupplyFault = (stateFf == apss_pkg::APSS_FAULT); // RL8
  assign photoGainSel = photoFf[apss_pkg::FldGainLo +: 2]; // RL10
  assign photoGainRefSel = photoFf[apss_pkg::FldRefSel]; // RL12
  assign photoInputAmpOn = photoFf[apss_pkg::FldInAmp];
  assign photoGainAmpOn = photoFf[apss_pkg::FldGainAmp];
  // low reference only with select set and at least one amplifier running
  assign photoRefLow = photoFf[apss_pkg::FldRefSel] &&
    (photoFf[apss_pkg::FldInAmp] || photoFf[apss_pkg::FldGainAmp]); // RL9
  assign coreRegulatorOn = 1'b1; // RL13
endmodule : apss_supervisor
`default_nettype wire

//--- bench/apss_supervisor_chk.sv
// Purpose: port-level timing checks on the host-supply supervisor
// Assumes: one clock, async active-high reset
// Notes: counters track reset release and raw good-low time
`timescale 1ns/10ps
`default_nettype none
module apss_supervisor_chk #(
  parameter int unsigned InitCycles = 20,
  parameter int unsigned StrapCycles = 10,
  parameter int unsigned ErrCycles = 40,
  parameter int unsigned FiltCycles = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic hostSupplyGoodRaw,
  input wire logic hostRegulatorOn,
  input wire logic hostAccessOk,
  input wire logic hostSupplyFault,
  input wire logic photoRefLow,
  input wire logic photoGainRefSel,
  input wire logic [1:0] photoGainSel,
  input wire logic photoInputAmpOn,
  input wire logic photoGainAmpOn,
  input wire logic coreRegulatorOn
);
  int unsigned upCnt_ff;
  int unsigned lowCnt_ff;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // helper counts; upCnt_ff saturates so a long run cannot wrap
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      upCnt_ff <= 0;
      lowCnt_ff <= 0;
    end
    else
    begin
      if (upCnt_ff < 100000) upCnt_ff <= upCnt_ff + 1;
      lowCnt_ff <= (hostRegulatorOn && !hostSupplyGoodRaw) ?
                   lowCnt_ff + 1 : 0;
    end
  end
  // ==========================================================
  // assertions
  a_core_on: assert property (coreRegulatorOn)
    else $error("core regulator off");
  a_seq_wait: assert property (upCnt_ff < InitCycles + StrapCycles
    |-> !hostRegulatorOn && !hostAccessOk) else $error("early power-up step");
  a_access_good: assert property ($rose(hostAccessOk)
    |-> hostRegulatorOn && $past(hostSupplyGoodRaw, FiltCycles))
    else $error("host access without power-good");
  a_access_keep: assert property (hostAccessOk |=> hostAccessOk)
    else $error("host access dropped");
  a_rd_idle: assert property (!regRdEn |=> regRdData == 8'h00)
    else $error("read data outside its cycle");
  a_rd_core: assert property (regRdEn && regAddr == 4'h3
    |=> regRdData == 8'h01) else $error("core status wrong");
  a_ref_low: assert property (photoRefLow == (photoGainRefSel
    && (photoInputAmpOn || photoGainAmpOn))) else $error("reference wrong");
  a_gain_now: assert property (regWrEn && regAddr == 4'h1
    && hostAccessOk |=> photoGainSel == $past(regWrData[1:0]))
    else $error("gain late");
  a_err_wait: assert property ($rose(hostSupplyFault)
    |-> lowCnt_ff >= ErrCycles - 1) else $error("fault too early");
endmodule : apss_supervisor_chk
bind apss_supervisor apss_supervisor_chk #(.InitCycles(InitCycles),
  .StrapCycles(StrapCycles), .ErrCycles(ErrCycles), .FiltCycles(FiltCycles))
  i_chk (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .hostSupplyGoodRaw(hostSupplyGoodRaw),
  .hostRegulatorOn(hostRegulatorOn), .hostAccessOk(hostAccessOk),
  .hostSupplyFault(hostSupplyFault), .photoRefLow(photoRefLow),
  .photoGainRefSel(photoGainRefSel), .photoGainSel(photoGainSel),
  .photoInputAmpOn(photoInputAmpOn), .photoGainAmpOn(photoGainAmpOn),
  .coreRegulatorOn(coreRegulatorOn));
`default_nettype wire

//--- bench/apss_reg_model.sv
// Purpose: behavioural host regulator driving the raw power-good
// Assumes: rail charges in RiseCyc cycles once enabled
// Notes: failOn holds the rail below threshold, glitchOn dips it
`timescale 1ns/10ps
`default_nettype none
module apss_reg_model #(
  parameter int unsigned RiseCyc = 8
) (
  input wire logic clk_sys,
  input wire logic regOn,
  input wire logic failOn,
  input wire logic glitchOn,
  output logic goodRaw
);
  int unsigned riseCnt_ff;
  // ==========================================================
  // charge timer; restarts on every enable, so good is never instant
  always_ff @(posedge clk_sys)
  begin
    if (!regOn || failOn) riseCnt_ff <= 0;
    else if (riseCnt_ff < RiseCyc) riseCnt_ff <= riseCnt_ff + 1;
  end
  assign goodRaw = (riseCnt_ff == RiseCyc) && !glitchOn;
endmodule : apss_reg_model
`default_nettype wire

//--- bench/apss_supervisor_bench.sv
// Purpose: self-checking bench for the host-supply supervisor
// Assumes: shortened counts 20/10/40/5, regulator model on good input
// Notes: fault is left by masking, since recovery needs power-good or the regulator off
`timescale 1ns/10ps
`default_nettype none
module apss_supervisor_bench;
  localparam int unsigned ErrC = 40;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [1:0] strap = 2'h0;
  logic failOn = 1'b0;
  logic glitchOn = 1'b0;
  logic [7:0] regRdData, rdv;
  logic goodRaw, regOn, accessOk, fault, refLow;
  logic refSel, inAmp, gainAmp, coreOn;
  logic [1:0] setting, gainSel;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  apss_supervisor #(.InitCycles(20), .StrapCycles(10), .ErrCycles(ErrC),
    .FiltCycles(5)) i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .supplySelectStrap(strap),
    .hostSupplyGoodRaw(goodRaw), .hostRegulatorOn(regOn),
    .hostSupplySetting(setting), .hostAccessOk(accessOk),
    .hostSupplyFault(fault), .photoRefLow(refLow), .photoGainRefSel(refSel),
    .photoGainSel(gainSel), .photoInputAmpOn(inAmp),
    .photoGainAmpOn(gainAmp), .coreRegulatorOn(coreOn));
  apss_reg_model i_reg (.clk_sys(clk_sys), .regOn(regOn), .failOn(failOn),
    .glitchOn(glitchOn), .goodRaw(goodRaw));
  // ==========================================================
  // clock and hang guard; the whole run needs well under 2000 cycles
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  // ==========================================================
  // bus cycles and comparison
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 rdv = regRdData;
  endtask : rd
  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // ==========================================================
  // scenarios
  task automatic t_powerup(input logic [1:0] s);
    @(posedge clk_sys);
    strap <= s;
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("reset outs", {5'h0, regOn, accessOk, coreOn}, 8'h01);
    rst <= 1'b0;
    // early write must be dropped, else the regulator never comes on
    wr(4'h0, {4'h0, 2'h3, ~s});
    for (int i = 0; i < 200 && accessOk !== 1'b1; i++) @(posedge clk_sys);
    #1 chk("setting", {6'h0, setting}, {6'h0, s});
    rd(4'h2);
    chk("status", rdv, 8'h39);
    rd(4'h3);
    chk("core reg", rdv, 8'h01);
    rd(4'hf);
    chk("unmapped", rdv, 8'h00);
  endtask : t_powerup
  task automatic t_levels();
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h0, 8'(i));
      chk("level out", {6'h0, setting}, 8'(i));
      rd(4'h0);
      chk("level reg", rdv, 8'(i));
    end
  endtask : t_levels
  task automatic t_photo();
    logic [7:0] e;
    logic [7:0] got;
    for (int v = 0; v < 32; v++)
    begin
      e = 8'(v);
      e[5] = e[2] & (e[3] | e[4]);
      wr(4'h1, 8'(v));
      got = {2'h0, refLow, gainAmp, inAmp, refSel, gainSel};
      chk("photo", got, e);
    end
  endtask : t_photo
  task automatic t_glitch();
    glitchOn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    glitchOn <= 1'b0;
    rd(4'h2);
    repeat (8) @(posedge clk_sys);
    rd(4'h2);
    chk("short dip", rdv & 8'h07, 8'h01);
    glitchOn <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rd(4'h2);
    glitchOn <= 1'b0;
    chk("long dip", rdv & 8'h07, 8'h00);
    repeat (20) @(posedge clk_sys);
  endtask : t_glitch
  task automatic t_disable();
    wr(4'h0, 8'h04);
    chk("reg off", {7'h0, regOn}, 8'h00);
    wr(4'h0, 8'h00);
    repeat (30) @(posedge clk_sys);
    rd(4'h2);
    chk("reg back", {7'h0, regOn}, 8'h01);
    chk("good back", rdv & 8'h07, 8'h01);
  endtask : t_disable
  task automatic t_error();
    wr(4'h0, 8'h08);
    failOn <= 1'b1;
    wr(4'h0, 8'h09); // a level change restarts the error timer
    repeat (ErrC / 2) @(posedge clk_sys);
    rd(4'h2);
    chk("err early", rdv & 8'h07, 8'h00);
    repeat (ErrC) @(posedge clk_sys);
    rd(4'h2);
    chk("err masked", {fault, 4'h0, rdv[2:0]}, 8'h02);
    wr(4'h0, 8'h01);
    repeat (3) @(posedge clk_sys);
    #1 chk("fault", {7'h0, fault}, 8'h01);
    wr(4'h0, 8'h09);
    repeat (3) @(posedge clk_sys);
    #1 chk("fault masked", {7'h0, fault}, 8'h00);
    failOn <= 1'b0;
    repeat (30) @(posedge clk_sys);
    rd(4'h2);
    chk("err clear", rdv & 8'h07, 8'h01);
  endtask : t_error
  initial
  begin
    t_powerup(2'h3);
    t_levels();
    t_photo();
    t_glitch();
    t_disable();
    t_error();
    t_powerup(2'h1);
    finish_test();
  end
endmodule : apss_supervisor_bench
`default_nettype wire
